// ---- rtl/ara_defines.vh ----
// Register map, field positions, reset values and mode codes of the result registers.
// Assumes an APB slave with 32-bit data, one aligned word per register.
`ifndef ARA_DEFINES_VH
`define ARA_DEFINES_VH

`define ARA_OFF_FILTER_OUT_HIGH 8'h00
`define ARA_OFF_FILTER_OUT_LOW 8'h04
`define ARA_OFF_SAMPLE_VALUE_HIGH 8'h08
`define ARA_OFF_SAMPLE_VALUE_LOW 8'h0C
`define ARA_OFF_PRIOR_VALUE_HIGH 8'h10
`define ARA_OFF_PRIOR_VALUE_LOW 8'h14
`define ARA_OFF_RUNNING_SUM_UPPER 8'h18
`define ARA_OFF_RUNNING_SUM_HIGH 8'h1C
`define ARA_OFF_RUNNING_SUM_LOW 8'h20
`define ARA_OFF_CONVERTER_CTRL 8'h24
`define ARA_OFF_STATUS 8'h28

`define ARA_CTRL_MODE_LSB 0
`define ARA_CTRL_MODE_MSB 2
`define ARA_CTRL_SHIFT_LSB 4
`define ARA_CTRL_SHIFT_MSB 6
`define ARA_CTRL_JUSTIFY 8
`define ARA_CTRL_PREV_SRC 9
`define ARA_CTRL_START 16

`define ARA_MODE_BASIC 3'h0
`define ARA_MODE_ACCUMULATE 3'h1
`define ARA_MODE_AVERAGE 3'h2
`define ARA_MODE_BURST_AVERAGE 3'h3
`define ARA_MODE_LOWPASS 3'h4

`define ARA_RESET_CTRL 10'h000
`define ARA_RESET_ACC 18'h00000
`define ARA_RESET_SAMPLE 12'h000
`define ARA_RESET_PRIOR 16'h0000
`define ARA_RESET_FILTER 16'h0000

`endif

// ---- rtl/ara_byte_format.v ----
// Formats the 12-bit sample into its high and low bytes per justification,
// and spreads the 18-bit running sum over three sign-extended bytes.
// Assumes purely combinational use by the register block.
module ara_byte_format (
    // Sample side
    input wire [11:0] sample,
    input wire justify_select,
    // Running sum side
    input wire [17:0] running_sum,
    // Formatted bytes
    output reg [15:0] sample_pair,
    output wire [23:0] sum_word
);

    always @* begin
        if (justify_select) begin
            sample_pair = {4'h0, sample};
        end else begin
            sample_pair = {sample, 4'h0};
        end
    end

    // Upper six bits copy the sign so the word reads as a 24-bit value
    assign sum_word = {{6{running_sum[17]}}, running_sum};

endmodule // ara_byte_format

// ---- rtl/ara_result_regs.v ----
// Result registers of a 12-bit converter with computation unit, as an APB slave.
// Assumes the conversion engine supplies done, result, accumulate and low-pass strobes on pclk.
`include "ara_defines.vh"

module ara_result_regs (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Conversion engine
    input wire conv_done,
    input wire [11:0] conv_sample,
    input wire acc_load,
    input wire [17:0] acc_value,
    input wire lpf_load,
    input wire [15:0] lpf_value,
    // Status to the engine
    output reg conversion_busy,
    output reg [2:0] computation_mode,
    output reg [2:0] shift_amount
);

    reg [9:0] ctrl_reg;
    reg busy_reg;
    reg [11:0] sample_reg;
    reg [17:0] acc_reg;
    reg [15:0] filter_reg;
    reg [15:0] prior_reg;
    reg [15:0] filter_next;
    reg [31:0] rdata_next;
    reg addr_ok;
    reg sel_ctrl;
    reg sel_sample_high;
    reg sel_sample_low;
    reg sel_sum_upper;
    reg sel_sum_high;
    reg sel_sum_low;

    wire [15:0] sample_pair;
    wire [23:0] sum_word;
    wire justify_select = ctrl_reg[`ARA_CTRL_JUSTIFY];
    wire previous_source_select = ctrl_reg[`ARA_CTRL_PREV_SRC];
    wire [2:0] mode = ctrl_reg[`ARA_CTRL_MODE_MSB:`ARA_CTRL_MODE_LSB];
    wire [2:0] shift = ctrl_reg[`ARA_CTRL_SHIFT_MSB:`ARA_CTRL_SHIFT_LSB];
    // Zero-wait slave: the access phase completes in its first cycle
    wire setup = psel & ~penable;
    // Writes land at the access edge, where the master samples pready high
    wire wr = psel & penable & pready & pwrite;
    wire wr_byte = wr & pstrb[0];
    wire start_req = wr & sel_ctrl & pstrb[2] & pwdata[`ARA_CTRL_START] & ~busy_reg;

    ara_byte_format u_fmt (
        .sample(sample_reg),
        .justify_select(justify_select),
        .running_sum(acc_reg),
        .sample_pair(sample_pair),
        .sum_word(sum_word)
    );

    function [15:0] shifted_sum;
        input [17:0] sum;
        input [2:0] amount;
        reg signed [17:0] s;
        begin
            s = $signed(sum) >>> amount;
            shifted_sum = s[15:0];
        end
    endfunction

    function is_addr;
        input [7:0] a;
        begin
            is_addr = (a == `ARA_OFF_FILTER_OUT_HIGH) || (a == `ARA_OFF_FILTER_OUT_LOW) ||
                      (a == `ARA_OFF_SAMPLE_VALUE_HIGH) || (a == `ARA_OFF_SAMPLE_VALUE_LOW) ||
                      (a == `ARA_OFF_PRIOR_VALUE_HIGH) || (a == `ARA_OFF_PRIOR_VALUE_LOW) ||
                      (a == `ARA_OFF_RUNNING_SUM_UPPER) || (a == `ARA_OFF_RUNNING_SUM_HIGH) ||
                      (a == `ARA_OFF_RUNNING_SUM_LOW) || (a == `ARA_OFF_CONVERTER_CTRL) ||
                      (a == `ARA_OFF_STATUS);
        end
    endfunction

    // One select per writable register; read-only and unmapped offsets select nothing
    always @* begin
        sel_ctrl = 1'b0;
        sel_sample_high = 1'b0;
        sel_sample_low = 1'b0;
        sel_sum_upper = 1'b0;
        sel_sum_high = 1'b0;
        sel_sum_low = 1'b0;
        if (paddr == `ARA_OFF_CONVERTER_CTRL) begin
            sel_ctrl = 1'b1;
        end else if (paddr == `ARA_OFF_SAMPLE_VALUE_HIGH) begin
            sel_sample_high = 1'b1;
        end else if (paddr == `ARA_OFF_SAMPLE_VALUE_LOW) begin
            sel_sample_low = 1'b1;
        end else if (paddr == `ARA_OFF_RUNNING_SUM_UPPER) begin
            sel_sum_upper = 1'b1;
        end else if (paddr == `ARA_OFF_RUNNING_SUM_HIGH) begin
            sel_sum_high = 1'b1;
        end else if (paddr == `ARA_OFF_RUNNING_SUM_LOW) begin
            sel_sum_low = 1'b1;
        end
    end

    // Filter source: low-pass value in low-pass mode, else shifted running sum
    // Basic mode and the unused mode codes hold the last filter value
    always @* begin
        filter_next = filter_reg;
        if (mode == `ARA_MODE_LOWPASS) begin
            if (lpf_load) begin
                filter_next = lpf_value;
            end
        end else if (mode == `ARA_MODE_ACCUMULATE) begin
            filter_next = shifted_sum(acc_reg, shift);
        end else if (mode == `ARA_MODE_AVERAGE) begin
            filter_next = shifted_sum(acc_reg, shift);
        end else if (mode == `ARA_MODE_BURST_AVERAGE) begin
            filter_next = shifted_sum(acc_reg, shift);
        end
    end

    always @* begin
        addr_ok = is_addr(paddr);
        rdata_next = 32'h00000000;
        if (paddr == `ARA_OFF_FILTER_OUT_HIGH) begin
            rdata_next = {24'h000000, filter_reg[15:8]};
        end else if (paddr == `ARA_OFF_FILTER_OUT_LOW) begin
            rdata_next = {24'h000000, filter_reg[7:0]};
        end else if (paddr == `ARA_OFF_SAMPLE_VALUE_HIGH) begin
            rdata_next = {24'h000000, sample_pair[15:8]};
        end else if (paddr == `ARA_OFF_SAMPLE_VALUE_LOW) begin
            rdata_next = {24'h000000, sample_pair[7:0]};
        end else if (paddr == `ARA_OFF_PRIOR_VALUE_HIGH) begin
            rdata_next = {24'h000000, prior_reg[15:8]};
        end else if (paddr == `ARA_OFF_PRIOR_VALUE_LOW) begin
            rdata_next = {24'h000000, prior_reg[7:0]};
        end else if (paddr == `ARA_OFF_RUNNING_SUM_UPPER) begin
            rdata_next = {24'h000000, sum_word[23:16]};
        end else if (paddr == `ARA_OFF_RUNNING_SUM_HIGH) begin
            rdata_next = {24'h000000, sum_word[15:8]};
        end else if (paddr == `ARA_OFF_RUNNING_SUM_LOW) begin
            rdata_next = {24'h000000, sum_word[7:0]};
        end else if (paddr == `ARA_OFF_CONVERTER_CTRL) begin
            rdata_next = {15'h0000, busy_reg, 6'h00, ctrl_reg};
        end else if (paddr == `ARA_OFF_STATUS) begin
            rdata_next = {31'h00000000, busy_reg};
        end
    end

    // Bus answer: registered, valid in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~addr_ok;
        end
    end

    // Read data is zero outside a read access so stale bytes never show on the bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata <= rdata_next;
        end else begin
            prdata <= 32'h00000000;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `ARA_RESET_CTRL;
        end else if (wr && sel_ctrl) begin
            if (pstrb[0]) begin
                ctrl_reg[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                ctrl_reg[9:8] <= pwdata[9:8];
            end
        end
    end

    // Start is checked before completion but is masked while busy, so a start in the done cycle is lost
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg <= 1'b0;
        end else if (start_req) begin
            busy_reg <= 1'b1;
        end else if (conv_done) begin
            busy_reg <= 1'b0;
        end
    end

    // Capture uses the values standing before this cycle's updates; a source
    // select written together with the start applies from the next start on
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prior_reg <= `ARA_RESET_PRIOR;
        end else if (start_req) begin
            if (previous_source_select) begin
                prior_reg <= filter_reg;
            end else begin
                prior_reg <= sample_pair;
            end
        end
    end

    // Engine result wins over a bus write in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_reg <= `ARA_RESET_SAMPLE;
        end else if (conv_done && busy_reg) begin
            sample_reg <= conv_sample;
        end else if (wr_byte && sel_sample_low) begin
            if (justify_select) begin
                sample_reg[7:0] <= pwdata[7:0];
            end else begin
                sample_reg[3:0] <= pwdata[7:4];
            end
        end else if (wr_byte && sel_sample_high) begin
            if (justify_select) begin
                sample_reg[11:8] <= pwdata[3:0];
            end else begin
                sample_reg[11:4] <= pwdata[7:0];
            end
        end
    end

    // Bus writes to the sum are dropped while a conversion runs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= `ARA_RESET_ACC;
        end else if (acc_load && busy_reg) begin
            acc_reg <= acc_value;
        end else if (wr_byte && !busy_reg) begin
            if (sel_sum_upper) begin
                acc_reg[17:16] <= pwdata[1:0];
            end else if (sel_sum_high) begin
                acc_reg[15:8] <= pwdata[7:0];
            end else if (sel_sum_low) begin
                acc_reg[7:0] <= pwdata[7:0];
            end
        end
    end

    // Filter lags a running sum change by one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_reg <= `ARA_RESET_FILTER;
        end else begin
            filter_reg <= filter_next;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_busy <= 1'b0;
            computation_mode <= 3'h0;
            shift_amount <= 3'h0;
        end else begin
            conversion_busy <= busy_reg;
            computation_mode <= mode;
            shift_amount <= shift;
        end
    end

endmodule // ara_result_regs

// ---- testbench/ara_result_regs_properties.sv ----
// Port-level checks for the result register block.
// Assumes it is bound onto ara_result_regs and sees one pclk domain.
module ara_result_regs_properties (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Status
    input wire conversion_busy,
    input wire [2:0] computation_mode,
    input wire [2:0] shift_amount
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ctrl_wr;
        s_setup ##0 (pwrite && paddr == 8'h24 && pstrb[0]);
    endsequence
    sequence s_start;
        s_setup ##0 (pwrite && paddr == 8'h24 && pstrb[2] && pwdata[16] && !conversion_busy);
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready) else $error("ready missing after setup");
    a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    a_unmapped_error: assert property (s_setup ##0 paddr > 8'h28 |=> pslverr) else $error("no error on unmapped");
    a_sum_sign_copies: assert property (pready && !pwrite && paddr == 8'h18 |->
        prdata == {24'h0, {6{prdata[1]}}, prdata[1:0]}) else $error("sum upper byte bad");
    // The write lands at the access edge, the mode copy follows one edge later
    a_mode_copy: assert property (s_ctrl_wr |=> ##2 computation_mode == $past(pwdata[2:0], 3))
        else $error("mode not copied");
    a_shift_copy: assert property (s_ctrl_wr |=> ##2 shift_amount == $past(pwdata[6:4], 3))
        else $error("shift not copied");
    a_busy_on_start: assert property (s_start |-> ##[1:3] conversion_busy) else $error("busy not raised on start");
endmodule // ara_result_regs_properties

// ---- testbench/ara_result_regs_tb_top.sv ----
// Self-checking bench for the result register block.
// Assumes APB answers within a few cycles; the bench plays the conversion engine.
module ara_result_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rdat;
    logic [3:0] pstrb = 0;
    logic conv_done = 0, acc_load = 0, lpf_load = 0;
    logic [11:0] conv_sample = 0;
    logic [17:0] acc_value = 0;
    logic [15:0] lpf_value = 0;
    wire [31:0] prdata;
    wire pready, pslverr, conversion_busy;
    wire [2:0] computation_mode, shift_amount;
    int err_total = 0, samples_checked = 0, cyc = 0;
    ara_result_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .conv_sample(conv_sample), .acc_load(acc_load), .acc_value(acc_value),
        .lpf_load(lpf_load), .lpf_value(lpf_value), .conversion_busy(conversion_busy),
        .computation_mode(computation_mode), .shift_amount(shift_amount));
    initial begin
        forever #5 pclk = ~pclk;
    end
    task results;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task apb(input [7:0] a, input w, input [31:0] d, input [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // A missing answer is caught by the cycle ceiling
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task rd(input string nm, input [7:0] a, input [31:0] e);
        apb(a, 1'b0, 32'h0, 4'h0);
        chk(nm, e, rdat);
    endtask
    task start(input [2:0] m, input [2:0] sh, input j, input p);
        apb(8'h24, 1'b1, {15'h0, 1'b1, 6'h0, p, j, 1'b0, sh, 1'b0, m}, 4'h7);
    endtask
    // Engine pulse: bit 0 done, bit 1 sum load, bit 2 low-pass load
    task eng(input [2:0] k, input [17:0] v);
        conv_done <= k[0];
        acc_load <= k[1];
        lpf_load <= k[2];
        conv_sample <= v[11:0];
        acc_value <= v;
        lpf_value <= v[15:0];
        @(posedge pclk);
        conv_done <= 1'b0;
        acc_load <= 1'b0;
        lpf_load <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task t_justify;
        start(3'h0, 3'h0, 1'b0, 1'b0);
        eng(3'h1, 18'h00ABC);
        rd("sample_value_high", 8'h08, 32'hAB);
        rd("sample_value_low", 8'h0C, 32'hC0);
        apb(8'h24, 1'b1, 32'h100, 4'h3);
        rd("sample_value_high", 8'h08, 32'h0A);
        rd("sample_value_low", 8'h0C, 32'hBC);
    endtask
    task t_prior;
        start(3'h0, 3'h0, 1'b1, 1'b0);
        eng(3'h1, 18'h00123);
        start(3'h0, 3'h0, 1'b1, 1'b0);
        eng(3'h1, 18'h00456);
        rd("prior_value_high", 8'h10, 32'h01);
        rd("prior_value_low", 8'h14, 32'h23);
    endtask
    task t_accum;
        start(3'h1, 3'h2, 1'b1, 1'b0);
        rd("status", 8'h28, 32'h1);
        chk("conversion_busy", 32'h1, {31'h0, conversion_busy});
        chk("computation_mode", 32'h1, {29'h0, computation_mode});
        chk("shift_amount", 32'h2, {29'h0, shift_amount});
        eng(3'h2, 18'h3FFF0);
        rd("filter_out_high", 8'h00, 32'hFF);
        rd("filter_out_low", 8'h04, 32'hFC);
        rd("running_sum_upper", 8'h18, 32'hFF);
        rd("running_sum_high", 8'h1C, 32'hFF);
        // Busy: this write must be dropped
        apb(8'h20, 1'b1, 32'h55, 4'h1);
        rd("running_sum_low", 8'h20, 32'hF0);
        eng(3'h1, 18'h0);
        // Select the filter as source ahead of the start, in burst average mode
        apb(8'h24, 1'b1, 32'h323, 4'h3);
        start(3'h2, 3'h2, 1'b1, 1'b1);
        eng(3'h1, 18'h0);
        rd("prior_value_high", 8'h10, 32'hFF);
        rd("prior_value_low", 8'h14, 32'hFC);
        apb(8'h20, 1'b1, 32'h55, 4'h1);
        rd("running_sum_low", 8'h20, 32'h55);
        apb(8'h18, 1'b1, 32'h01, 4'h1);
        rd("running_sum_upper", 8'h18, 32'h01);
    endtask
    task t_lowpass;
        start(3'h4, 3'h0, 1'b1, 1'b0);
        eng(3'h5, 18'h08123);
        apb(8'h00, 1'b1, 32'h0, 4'h1);
        rd("filter_out_high", 8'h00, 32'h81);
        rd("filter_out_low", 8'h04, 32'h23);
        apb(8'h40, 1'b0, 32'h0, 4'h0);
        chk("pslverr", 32'h1, {31'h0, rerr});
    endtask
    // Reset between runs must clear the mode copy, running sum, filter and prior value
    task t_reset;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("computation_mode", 32'h0, {29'h0, computation_mode});
        rd("running_sum_low", 8'h20, 32'h0);
        rd("filter_out_high", 8'h00, 32'h0);
        rd("prior_value_low", 8'h14, 32'h0);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("converter_ctrl_two", 8'h24, 32'h0);
        t_justify;
        t_prior;
        t_accum;
        t_lowpass;
        t_reset;
        results;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            results;
        end
    end
endmodule // ara_result_regs_tb_top

bind ara_result_regs ara_result_regs_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conversion_busy(conversion_busy),
    .computation_mode(computation_mode), .shift_amount(shift_amount));
